// ### design/dpe_pkg.sv
// Package of constants for the diagnostic port evaluator
`default_nettype none
package dpe_pkg;
   localparam int unsigned DPE_CHAN_PORTS = 4;
   localparam int unsigned DPE_PORT_W = 8;
   localparam logic [7:0] DPE_PINS_IDLE = 8'hFF;
   localparam logic [7:0] DPE_MASK_RST = 8'h00;
   localparam int unsigned DPE_GATE_BIT = 3;
   localparam logic [3:0] DPE_PRM_USER1 = 4'h7;
   localparam logic [3:0] DPE_PRM_MASK_F = 4'h8;
   localparam logic [3:0] DPE_PRM_MASK_I = 4'hB;
   localparam logic [2:0] DPE_ADDR_STATUS = 3'h0;
   localparam logic [2:0] DPE_ADDR_IRQ_MASK = 3'h1;
   localparam logic [2:0] DPE_ADDR_FAULTS = 3'h2;
   localparam logic [2:0] DPE_ADDR_CTRL = 3'h3;
   localparam int unsigned DPE_EV_CHANGE = 0;
   localparam int unsigned DPE_EV_FAULT = 1;
   localparam int unsigned DPE_EV_W = 2;
endpackage
`default_nettype wire

// ### design/dpe_evaluator.sv
// Diagnostic port sampling, masking, fault output and change reporting
//
// Design decisions made here: the register offsets and strobed register access.
`default_nettype none
// Functional notes
// R1 - Extended diagnosis gives four channel diagnostic ports F to I.
// R2 - Memory-present strap high adds general diagnostic ports J and K.
// R3 - Diagnostic ports are sampled in the same strobe as data ports.
// R4 - A low pin on a channel diagnostic port is an active-high error.
// R5 - Each channel bit has a mask; mask one suppresses its error.
// R6 - Reset clears all channel masks so every error propagates.
// R7 - Master writes zero masks when no diagnostic ports are configured.
// R8 - Ports J and K are eight bits wide and never masked.
// R9 - Gate flag zero: any low pin on J raises the fault pin.
// R10 - Gate flag one: J errors count only with a channel error present.
// R11 - Any K error always raises the fault pin.
// R12 - Fault pin high while an unmasked error level is applied, else low.
// R13 - New sample compared with previous; each change reported once.
// R14 - Gate flag is bit 3 of first user parameter byte, resets zero.
// R15 - Parameter bytes 8 to 11 load masks for F, G, H, I.
// R16 - Previous image resets to no-error and updates every sample.
module dpe_evaluator
   import dpe_pkg::*;
(
   input wire logic clk,
   input wire logic rst_b,
   input wire logic ext_diag_en,
   input wire logic param_memory_present,
   input wire logic [3:0][7:0] chan_pins,
   input wire logic [7:0] gen_j_pins,
   input wire logic [7:0] gen_k_pins,
   input wire logic sample_stb,
   input wire logic prm_wr,
   input wire logic [3:0] prm_idx,
   input wire logic [7:0] prm_data,
   input wire logic [2:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata,
   output logic diag_fault_pin,
   output logic report_req,
   output logic [3:0][7:0] diag_img,
   output logic [7:0] diag_img_j,
   output logic [7:0] diag_img_k,
   output logic irq
);
   import dpe_pkg::*;

   // ****************************************
   // State
   // ****************************************
   typedef struct packed {
      logic [3:0][7:0] chan_s1;
      logic [3:0][7:0] chan_s2;
      logic [7:0] j_s1;
      logic [7:0] j_s2;
      logic [7:0] k_s1;
      logic [7:0] k_s2;
      logic ext_s1;
      logic ext_s2;
      logic mem_s1;
      logic mem_s2;
      logic [3:0][7:0] mask;
      logic gate;
      logic [3:0][7:0] chan_img;
      logic [7:0] j_img;
      logic [7:0] k_img;
      logic fault;
      logic report;
      logic [DPE_EV_W-1:0] status;
      logic [DPE_EV_W-1:0] irq_mask;
      logic [7:0] rdata;
   } dpe_state_t;

   dpe_state_t s_q;
   dpe_state_t s_d;

   function automatic logic [7:0] low_err(input logic [7:0] pins);
      return ~pins;
   endfunction

   logic [3:0][7:0] chan_err;
   logic [7:0] j_err;
   logic [7:0] k_err;
   logic chan_any;
   logic fault_now;
   logic changed;
   logic [DPE_EV_W-1:0] ev;

   // ****************************************
   // Next state
   // ****************************************
   always_comb begin
      s_d = s_q;
      // Pins are asynchronous: two flops before any use
      s_d.chan_s1 = chan_pins;
      s_d.chan_s2 = s_q.chan_s1;
      s_d.j_s1 = gen_j_pins;
      s_d.j_s2 = s_q.j_s1;
      s_d.k_s1 = gen_k_pins;
      s_d.k_s2 = s_q.k_s1;
      s_d.ext_s1 = ext_diag_en;
      s_d.ext_s2 = s_q.ext_s1;
      s_d.mem_s1 = param_memory_present;
      s_d.mem_s2 = s_q.mem_s1;

      // Masked channel errors, only when channel ports exist
      for (int p = 0; p < DPE_CHAN_PORTS; p++) begin
         if (s_q.ext_s2) begin // see R1
            chan_err[p] = low_err(s_q.chan_s2[p]) & ~s_q.mask[p]; // see R4 see R5
         end else begin
            chan_err[p] = '0;
         end
      end
      if (s_q.mem_s2) begin // see R2
         j_err = low_err(s_q.j_s2); // see R8
         k_err = low_err(s_q.k_s2); // see R8
      end else begin
         j_err = '0;
         k_err = '0;
      end
      chan_any = |chan_err;
      fault_now = chan_any | (|k_err); // see R11
      if (!s_q.gate) begin
         fault_now = fault_now | (|j_err); // see R9
      end else begin
         fault_now = fault_now | ((|j_err) & chan_any); // see R10
      end
      s_d.fault = fault_now; // see R12

      // Sample together with data read; report only on a difference
      changed = (chan_err != s_q.chan_img) || (j_err != s_q.j_img)
                || (k_err != s_q.k_img);
      s_d.report = sample_stb && changed; // see R13
      if (sample_stb) begin // see R3
         s_d.chan_img = chan_err; // see R16
         s_d.j_img = j_err;
         s_d.k_img = k_err;
      end

      // Parameter bytes from the telegram logic
      if (prm_wr) begin
         if (prm_idx == DPE_PRM_USER1) begin
            s_d.gate = prm_data[DPE_GATE_BIT]; // see R14
         end else if (prm_idx >= DPE_PRM_MASK_F && prm_idx <= DPE_PRM_MASK_I) begin
            s_d.mask[2'(prm_idx - DPE_PRM_MASK_F)] = prm_data; // see R15
         end
      end

      // Register port; set wins over read-clear
      ev = '0;
      ev[DPE_EV_CHANGE] = s_d.report;
      ev[DPE_EV_FAULT] = fault_now & ~s_q.fault;
      s_d.rdata = '0;
      if (reg_rd) begin
         if (reg_addr == DPE_ADDR_STATUS) begin
            s_d.rdata = 8'(s_q.status);
            s_d.status = '0;
         end else if (reg_addr == DPE_ADDR_IRQ_MASK) begin
            s_d.rdata = 8'(s_q.irq_mask);
         end else if (reg_addr == DPE_ADDR_FAULTS) begin
            s_d.rdata = {5'h0, s_q.mem_s2, s_q.gate, s_q.fault};
         end else if (reg_addr == DPE_ADDR_CTRL) begin
            s_d.rdata = {7'h0, s_q.gate};
         end
      end
      s_d.status = s_d.status | ev;
      if (reg_wr) begin
         if (reg_addr == DPE_ADDR_IRQ_MASK) begin
            s_d.irq_mask = reg_wdata[DPE_EV_W-1:0];
         end else if (reg_addr == DPE_ADDR_CTRL) begin
            s_d.gate = reg_wdata[DPE_GATE_BIT]; // see R14
         end
      end
   end

   // ****************************************
   // Registers
   // ****************************************
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         s_q <= '0;
         s_q.chan_s1 <= {4{DPE_PINS_IDLE}};
         s_q.chan_s2 <= {4{DPE_PINS_IDLE}};
         s_q.j_s1 <= DPE_PINS_IDLE;
         s_q.j_s2 <= DPE_PINS_IDLE;
         s_q.k_s1 <= DPE_PINS_IDLE;
         s_q.k_s2 <= DPE_PINS_IDLE;
         s_q.mask <= {4{DPE_MASK_RST}}; // see R6
      end else begin
         s_q <= s_d;
      end
   end

   assign diag_fault_pin = s_q.fault;
   assign report_req = s_q.report;
   assign diag_img = s_q.chan_img;
   assign diag_img_j = s_q.j_img;
   assign diag_img_k = s_q.k_img;
   assign reg_rdata = s_q.rdata;
   assign irq = |(s_q.status & s_q.irq_mask);

   // ****************************************
   // Checks
   // ****************************************
   a_k_fault_pin: assert property (@(posedge clk) disable iff (!rst_b) // see R11
      (s_q.mem_s2 && |low_err(s_q.k_s2)) |=> diag_fault_pin)
      else $error("K error did not raise fault");
   a_gate_blocks_j: assert property (@(posedge clk) disable iff (!rst_b) // see R10
      (s_q.gate && !chan_any && !(|k_err)) |=> !diag_fault_pin)
      else $error("Gated J error raised fault");
   a_j_ungated: assert property (@(posedge clk) disable iff (!rst_b) // see R9
      (!s_q.gate && |j_err) |=> diag_fault_pin)
      else $error("Ungated J error missing");
   a_mask_hides: assert property (@(posedge clk) disable iff (!rst_b) // see R5
      (s_q.ext_s2 && low_err(s_q.chan_s2[3]) != '0
       && (low_err(s_q.chan_s2[3]) & ~s_q.mask[3]) == '0
       && chan_err[0] == '0 && chan_err[1] == '0 && chan_err[2] == '0
       && j_err == '0 && k_err == '0) |=> !diag_fault_pin)
      else $error("Masked error propagated");
   a_report_once: assert property (@(posedge clk) disable iff (!rst_b) // see R13
      report_req |-> ($changed(diag_img) || $changed(diag_img_j)
      || $changed(diag_img_k)))
      else $error("Change reported twice");
   a_report_cause: assert property (@(posedge clk) disable iff (!rst_b) // see R16
      (sample_stb && changed) |=> report_req && diag_img == $past(chan_err))
      else $error("Change not reported");
   a_no_mem_jk: assert property (@(posedge clk) disable iff (!rst_b) // see R2
      (!s_q.mem_s2 && sample_stb) |=> (diag_img_j == '0 && diag_img_k == '0))
      else $error("J or K image without memory");
   a_gate_load: assert property (@(posedge clk) disable iff (!rst_b) // see R14
      (prm_wr && prm_idx == DPE_PRM_USER1 && !reg_wr) |=> s_q.gate == $past(prm_data[DPE_GATE_BIT]))
      else $error("Gate flag not loaded");

   // Reset checks carry no disable, so they see the reset itself
   a_mask_reset: assert property ( // see R6
      @(posedge clk)
      !rst_b
      |=> (s_q.mask == '0))
      else $error("Masks not cleared by reset");

   a_gate_reset: assert property ( // see R14
      @(posedge clk)
      !rst_b
      |=> !s_q.gate)
      else $error("Gate flag not cleared by reset");

   a_img_reset: assert property ( // see R16
      @(posedge clk)
      !rst_b
      |=> (diag_img == '0 && diag_img_j == '0 && diag_img_k == '0 && !report_req))
      else $error("Image not cleared by reset");

   a_chan_fault: assert property ( // see R4
      @(posedge clk) disable iff (!rst_b)
      (s_q.ext_s2 && (low_err(s_q.chan_s2[0]) & ~s_q.mask[0]) != '0)
      |=> diag_fault_pin)
      else $error("Channel error did not raise fault");

   a_fault_drops: assert property ( // see R12
      @(posedge clk) disable iff (!rst_b)
      (chan_err == '0 && j_err == '0 && k_err == '0)
      |=> !diag_fault_pin)
      else $error("Fault stayed without error");

   a_img_hold: assert property ( // see R3
      @(posedge clk) disable iff (!rst_b)
      !sample_stb
      |=> ($stable(diag_img) && $stable(diag_img_j) && $stable(diag_img_k)))
      else $error("Image moved without sample");

   a_idle_no_rep: assert property ( // see R13
      @(posedge clk) disable iff (!rst_b)
      !sample_stb
      |=> !report_req)
      else $error("Report without sample");

   a_same_no_rep: assert property ( // see R13
      @(posedge clk) disable iff (!rst_b)
      (sample_stb && !changed)
      |=> !report_req)
      else $error("Report without change");

   a_j_unmasked: assert property ( // see R8
      @(posedge clk) disable iff (!rst_b)
      (s_q.mem_s2 && !s_q.gate && low_err(s_q.j_s2) != '0)
      |=> diag_fault_pin)
      else $error("J error was masked");

   a_mask_load_f: assert property ( // see R15
      @(posedge clk) disable iff (!rst_b)
      (prm_wr && prm_idx == DPE_PRM_MASK_F)
      |=> (s_q.mask[0] == $past(prm_data)))
      else $error("First mask not loaded");

   a_mask_load_i: assert property ( // see R15
      @(posedge clk) disable iff (!rst_b)
      (prm_wr && prm_idx == DPE_PRM_MASK_I)
      |=> (s_q.mask[3] == $past(prm_data)))
      else $error("Last mask not loaded");

   a_no_ext_img: assert property ( // see R1
      @(posedge clk) disable iff (!rst_b)
      (!s_q.ext_s2 && sample_stb)
      |=> (diag_img == '0))
      else $error("Channel image without extended diagnosis");

   a_no_mem_fault: assert property ( // see R2
      @(posedge clk) disable iff (!rst_b)
      (!s_q.mem_s2 && chan_err == '0)
      |=> !diag_fault_pin)
      else $error("Fault from J or K without memory");

   a_k_beats_gate: assert property ( // see R11
      @(posedge clk) disable iff (!rst_b)
      (s_q.gate && s_q.mem_s2 && low_err(s_q.k_s2) != '0)
      |=> diag_fault_pin)
      else $error("K error gated");

   a_gate_ctrl: assert property ( // see R14
      @(posedge clk) disable iff (!rst_b)
      (reg_wr && reg_addr == DPE_ADDR_CTRL)
      |=> (s_q.gate == $past(reg_wdata[DPE_GATE_BIT])))
      else $error("Gate flag not written");

   a_img_masked: assert property ( // see R5
      @(posedge clk) disable iff (!rst_b)
      (sample_stb && s_q.ext_s2)
      |=> ((diag_img[0] & $past(s_q.mask[0])) == '0))
      else $error("Masked bit in image");

   a_j_img_raw: assert property ( // see R8
      @(posedge clk) disable iff (!rst_b)
      (sample_stb && s_q.mem_s2)
      |=> (diag_img_j == $past(low_err(s_q.j_s2))))
      else $error("J image wrong");

   a_k_img_raw: assert property ( // see R8
      @(posedge clk) disable iff (!rst_b)
      (sample_stb && s_q.mem_s2)
      |=> (diag_img_k == $past(low_err(s_q.k_s2))))
      else $error("K image wrong");
endmodule
`default_nettype wire

// ### bench/dpe_diag_hw.sv
// Model of the external hardware that drives the diagnostic pins
`default_nettype none
module dpe_diag_hw (
   input wire logic clk,
   output logic [3:0][7:0] chan_pins,
   output logic [7:0] gen_j_pins,
   output logic [7:0] gen_k_pins
);
   timeunit 1ns;
   timeprecision 1ps;
   // Pull-ups keep unused pins high, so idle means no error
   initial begin
      chan_pins = 32'hffff_ffff;
      gen_j_pins = 8'hff;
      gen_k_pins = 8'hff;
   end
   // Errors given active high, pins driven active low
   task automatic put(input logic [3:0][7:0] ce, input logic [7:0] je, input logic [7:0] ke);
      @(posedge clk);
      chan_pins <= ~ce;
      gen_j_pins <= ~je;
      gen_k_pins <= ~ke;
   endtask
endmodule
`default_nettype wire

// ### bench/dpe_evaluator_tb_top.sv
// Self-checking testbench of the diagnostic port evaluator
`default_nettype none
module dpe_evaluator_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   import dpe_pkg::*;
   logic clk = 1'b0, rst_b = 1'b0, ext_diag_en = 1'b1, param_memory_present = 1'b1;
   logic sample_stb = 1'b0, prm_wr = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
   logic [3:0] prm_idx = 4'h0;
   logic [7:0] prm_data = 8'h00, reg_wdata = 8'h00, reg_rdata, diag_img_j, diag_img_k, d;
   logic [2:0] reg_addr = 3'h0;
   logic [3:0][7:0] chan_pins, diag_img;
   logic [7:0] gen_j_pins, gen_k_pins;
   logic diag_fault_pin, report_req, irq, r;
   int n_errors = 0;
   int n_tests = 0;
   always #12.5 clk = ~clk;
   dpe_diag_hw i_hw (.clk, .chan_pins, .gen_j_pins, .gen_k_pins);
   dpe_evaluator i_dut (.clk, .rst_b, .ext_diag_en, .param_memory_present, .chan_pins,
      .gen_j_pins, .gen_k_pins, .sample_stb, .prm_wr, .prm_idx, .prm_data, .reg_addr,
      .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .diag_fault_pin, .report_req, .diag_img,
      .diag_img_j, .diag_img_k, .irq);
   // ****************
   // Helpers
   // ****************
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      n_tests++;
      if (got !== exp) begin
         n_errors++;
         $display("FAIL at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic prm(input logic [3:0] i, input logic [7:0] v);
      @(posedge clk);
      prm_wr <= 1'b1;
      prm_idx <= i;
      prm_data <= v;
      @(posedge clk);
      prm_wr <= 1'b0;
   endtask
   task automatic wr(input logic [2:0] a, input logic [7:0] v);
      @(posedge clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= v;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask
   task automatic rd(input logic [2:0] a, output logic [7:0] v);
      @(posedge clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1 v = reg_rdata;
   endtask
   task automatic smp(output logic rep);
      @(posedge clk);
      sample_stb <= 1'b1;
      @(posedge clk);
      sample_stb <= 1'b0;
      #1 rep = report_req;
   endtask
   // Sync chain is two flops plus the fault register
   task automatic settle();
      repeat (5) @(posedge clk);
      #1;
   endtask
   // ****************
   // Scenarios
   // ****************
   task automatic t_reset();
      chk(diag_fault_pin, 1'b0);
      chk(diag_img[0], 8'h00);
      chk(diag_img_k, 8'h00);
      rd(DPE_ADDR_FAULTS, d);
      chk(d, 8'h04);
      rd(3'h7, d);
      chk(d, 8'h00);
      wr(DPE_ADDR_CTRL, 8'h08);
      rd(DPE_ADDR_CTRL, d);
      chk(d, 8'h01);
      wr(DPE_ADDR_CTRL, 8'h00);
      $display("test reset done");
   endtask
   task automatic t_chan();
      wr(DPE_ADDR_IRQ_MASK, 8'h02);
      rd(DPE_ADDR_IRQ_MASK, d);
      chk(d, 8'h02);
      i_hw.put(32'h0000_0001, 8'h00, 8'h00);
      settle();
      chk(diag_fault_pin, 1'b1);
      chk(irq, 1'b1);
      rd(DPE_ADDR_STATUS, d);
      chk(d, 8'h02);
      chk(irq, 1'b0);
      smp(r);
      chk(r, 1'b1);
      chk(diag_img[0], 8'h01);
      smp(r);
      chk(r, 1'b0);
      i_hw.put(32'h0000_0000, 8'h00, 8'h00);
      settle();
      chk(diag_fault_pin, 1'b0);
      $display("test channel done");
   endtask
   task automatic t_mask();
      prm(DPE_PRM_MASK_F, 8'h01);
      i_hw.put(32'h8000_0001, 8'h00, 8'h00);
      settle();
      chk(diag_fault_pin, 1'b1);
      prm(DPE_PRM_MASK_I, 8'h80);
      settle();
      chk(diag_fault_pin, 1'b0);
      $display("test mask done");
   endtask
   task automatic t_gen();
      i_hw.put(32'h0000_0000, 8'h08, 8'h00);
      settle();
      chk(diag_fault_pin, 1'b1);
      smp(r);
      chk(r, 1'b1);
      chk(diag_img_j, 8'h08);
      chk(diag_img[0], 8'h00);
      prm(DPE_PRM_USER1, 8'h08);
      settle();
      chk(diag_fault_pin, 1'b0);
      i_hw.put(32'h0000_0200, 8'h08, 8'h00);
      settle();
      chk(diag_fault_pin, 1'b1);
      i_hw.put(32'h0000_0001, 8'h00, 8'h01);
      settle();
      chk(diag_fault_pin, 1'b1);
      smp(r);
      chk(diag_img_k, 8'h01);
      chk(diag_img[0], 8'h00);
      @(posedge clk);
      param_memory_present <= 1'b0;
      settle();
      chk(diag_fault_pin, 1'b0);
      smp(r);
      chk(diag_img_k, 8'h00);
      @(posedge clk);
      ext_diag_en <= 1'b0;
      prm(DPE_PRM_USER1, 8'h00);
      prm(DPE_PRM_MASK_F, 8'h00);
      prm(DPE_PRM_MASK_I, 8'h00);
      i_hw.put(32'h0000_0001, 8'h00, 8'h00);
      settle();
      chk(diag_fault_pin, 1'b0);
      smp(r);
      chk(diag_img[0], 8'h00);
      $display("test general done");
   endtask
   task automatic tally_and_finish();
      $display("Comparisons %0d, mismatches %0d", n_tests, n_errors);
      if (n_errors == 0 && n_tests > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   initial begin
      repeat (16) @(posedge clk);
      rst_b <= 1'b1;
      @(posedge clk);
      #1;
      t_reset();
      t_chan();
      t_mask();
      t_gen();
      tally_and_finish();
   end
   // Whole run needs about 120 cycles
   initial begin
      repeat (5000) @(posedge clk);
      n_errors++;
      tally_and_finish();
   end
endmodule
`default_nettype wire
